// ### design/anps_pkg.sv
// Purpose: constants shared by the partner status register block
// Assumes: 5-bit management register address, 16-bit register data
// Notes:   own interrupt registers sit above the standard register range
package anps_pkg;
    localparam int          ADDR_W          = 5;
    localparam int          DATA_W          = 16;
    // register offsets
    localparam logic [4:0]  LPA_ADDR        = 5'h05;
    localparam logic [4:0]  EXP_ADDR        = 5'h06;
    localparam logic [4:0]  IRQ_STAT_ADDR   = 5'h18;
    localparam logic [4:0]  IRQ_MASK_ADDR   = 5'h19;
    // partner ability fields
    localparam int          LPA_NP_BIT      = 15;
    localparam int          LPA_ACK_BIT     = 14;
    localparam int          LPA_RF_BIT      = 13;
    localparam int          LPA_TECH_HI     = 8;
    localparam int          LPA_TECH_LO     = 5;
    localparam int          LPA_SEL_HI      = 4;
    localparam int          LPA_SEL_LO      = 0;
    // bits 12:9 never load: reserved and unsupported ability
    localparam logic [15:0] LPA_LOAD_MASK   = 16'hE1FF;
    localparam logic [15:0] LPA_RESET       = 16'h0000;
    localparam logic [4:0]  SEL_IEEE_8023   = 5'h01;
    localparam logic [4:0]  SEL_IEEE_8029   = 5'h02;
    // expansion fields
    localparam int          EXP_PDF_BIT     = 4;
    localparam int          EXP_LPNP_BIT    = 3;
    localparam int          EXP_NPA_BIT     = 2;
    localparam int          EXP_PR_BIT      = 1;
    localparam int          EXP_LPAN_BIT    = 0;
    localparam logic        LOCAL_NP_ABLE   = 1'b1;
    // interrupt layout
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_PAGE_BIT    = 0;
    localparam int          IRQ_PDF_BIT     = 1;
    localparam int          IRQ_LPAN_BIT    = 2;
    localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;
endpackage

// ### design/anps_bus_if.sv
// Purpose: register strobes and decoded selects between top and decoder
// Assumes: single clock, strobes already one cycle long
// Notes:   decoder is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface anps_bus_if;
    logic [4:0] addr;
    logic       wr;
    logic       rd;
    logic       sel_lpa;
    logic       sel_exp;
    logic       sel_ist;
    logic       sel_imsk;
    logic       hit;
    modport src (output addr, output wr, output rd,
                 input sel_lpa, input sel_exp, input sel_ist, input sel_imsk, input hit);
    modport dec (input addr, input wr, input rd,
                 output sel_lpa, output sel_exp, output sel_ist, output sel_imsk, output hit);
endinterface
`default_nettype wire

// ### design/anps_decode.sv
// Purpose: address decode for the partner status registers
// Assumes: address stable beside its strobe
// Notes:   hit is low for unmapped addresses, which then read as zero
`timescale 1ns/1ps
`default_nettype none
module anps_decode
    import anps_pkg::*;
(
    // decoded bus
    anps_bus_if.dec bus
);
    assign bus.sel_lpa  = (bus.addr == LPA_ADDR);
    assign bus.sel_exp  = (bus.addr == EXP_ADDR);
    assign bus.sel_ist  = (bus.addr == IRQ_STAT_ADDR);
    assign bus.sel_imsk = (bus.addr == IRQ_MASK_ADDR);
    assign bus.hit      = bus.sel_lpa | bus.sel_exp | bus.sel_ist | bus.sel_imsk;
endmodule
`default_nettype wire

// ### design/anps_sticky.sv
// Purpose: one sticky flag, set by an event, cleared by software
// Assumes: set and clr come from the mclk domain
// Notes:   set wins over clr so an event in the clearing cycle survives
`timescale 1ns/1ps
`default_nettype none
module anps_sticky (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // control
    input  wire logic set,
    input  wire logic clr,
    // flag
    output logic      q
);
    logic q_reg;
    logic q_next;

    assign q_next = set ? 1'b1 : (clr ? 1'b0 : q_reg);
    assign q      = q_reg;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end
endmodule
`default_nettype wire

// ### design/anps_top.sv
// Purpose: partner ability and negotiation expansion status registers
// Assumes: negotiation inputs come from logic on mclk, no synchroniser needed
// Notes:   read data appear one cycle after the read strobe, zero otherwise
//
// Summary of operation
// - partner ability register loads from each received base link code word
// - bit 15 shows partner next page flag: one means more pages follow
// - bit 14 shows whether partner acknowledged our link code word
// - bit 13 shows partner remote fault from received code word
// - bits 8 to 5 show partner technology abilities, one per technology
// - reserved bits 12 to 10 and unsupported bit 9 always read zero
// - bits 4 to 0 expose partner selector; any code, 802.3 or other, reads back unchanged
// - expansion bit 3 is one when partner page advertises next page
// - expansion bit 2 is constant one: local next page supported
// - expansion bit 1 latches high on page received until read
// - expansion bit 4 latches high on parallel detection fault
// - expansion bit 0 is one while the burst detector reports valid partner pulse bursts, one cycle later
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module anps_top
    import anps_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // negotiation engine
    input  wire logic        rx_page_stb,
    input  wire logic        rx_page_base,
    input  wire logic [15:0] rx_page_word,
    input  wire logic        pd_fault_evt,
    input  wire logic        flp_partner_ok,
    // interrupt
    output logic             irq
);
    anps_bus_if bus ();

    logic [15:0]      lpa_reg;
    logic [15:0]      lpa_next;
    logic             lpan_reg;
    logic [15:0]      rdata_reg;
    logic [15:0]      rdata_next;
    logic             irq_reg;
    logic             irq_next;
    logic [IRQ_W-1:0] imask_reg;
    logic [IRQ_W-1:0] imask_next;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] ievt;
    logic [IRQ_W-1:0] iclr;
    logic             base_load;
    logic             exp_read;
    logic             pr_flag;
    logic             pdf_flag;
    logic             lpan_rise;
    logic [15:0]      lpa_word;
    logic [15:0]      exp_word;
    logic [15:0]      ist_word;
    logic [15:0]      imsk_word;
    logic [15:0]      rd_word;

    assign bus.addr = reg_addr;
    assign bus.wr   = reg_wr;
    assign bus.rd   = reg_rd;

    anps_decode u_decode (
        .bus (bus)
    );

    // only base pages describe partner abilities; next pages carry messages
    assign base_load = rx_page_stb & rx_page_base;
    // reserved and unsupported positions are masked at load so they stay zero
    assign lpa_next  = base_load ? (rx_page_word & LPA_LOAD_MASK) : lpa_reg;

    // the register is read-only: bus writes to it are dropped
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lpa_reg <= LPA_RESET;
        end else begin
            lpa_reg <= lpa_next;
        end
    end

    // software must wait for completion before trusting these bits
    assign lpa_word = {lpa_reg[LPA_NP_BIT],
                       lpa_reg[LPA_ACK_BIT],
                       lpa_reg[LPA_RF_BIT],
                       4'h0,
                       lpa_reg[LPA_TECH_HI:LPA_TECH_LO],
                       lpa_reg[LPA_SEL_HI:LPA_SEL_LO]};

    // partner ability level follows the burst detector one cycle later, through a register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lpan_reg <= 1'b0;
        end else begin
            lpan_reg <= flp_partner_ok;
        end
    end

    assign lpan_rise = flp_partner_ok & ~lpan_reg;

    // a read of the expansion register clears the latched flags
    assign exp_read = bus.rd & bus.sel_exp;

    anps_sticky u_page_rx (
        .mclk (mclk),
        .rstn (rstn),
        .set  (rx_page_stb),
        .clr  (exp_read),
        .q    (pr_flag)
    );

    // a fault still present at the read sets the flag again at once
    anps_sticky u_pd_fault (
        .mclk (mclk),
        .rstn (rstn),
        .set  (pd_fault_evt),
        .clr  (exp_read),
        .q    (pdf_flag)
    );

    assign exp_word = {11'h000,
                       pdf_flag,
                       lpa_reg[LPA_NP_BIT],
                       LOCAL_NP_ABLE,
                       pr_flag,
                       lpan_reg};

    // interrupt sources, write one to clear, set beats clear
    assign ievt[IRQ_PAGE_BIT] = rx_page_stb;
    assign ievt[IRQ_PDF_BIT]  = pd_fault_evt;
    assign ievt[IRQ_LPAN_BIT] = lpan_rise;

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
            assign iclr[gi] = bus.wr & bus.sel_ist & reg_wdata[gi];
            anps_sticky u_stat (
                .mclk (mclk),
                .rstn (rstn),
                .set  (ievt[gi]),
                .clr  (iclr[gi]),
                .q    (istat[gi])
            );
        end
    endgenerate

    assign imask_next = (bus.wr & bus.sel_imsk) ? reg_wdata[IRQ_W-1:0] : imask_reg;
    assign irq_next   = |(istat & imask_reg);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            imask_reg <= IRQ_MASK_RESET;
            irq_reg   <= 1'b0;
        end else begin
            imask_reg <= imask_next;
            irq_reg   <= irq_next;
        end
    end

    assign ist_word  = {{(DATA_W-IRQ_W){1'b0}}, istat};
    assign imsk_word = {{(DATA_W-IRQ_W){1'b0}}, imask_reg};

    // unmapped addresses read zero
    assign rd_word = bus.sel_lpa  ? lpa_word  :
                     bus.sel_exp  ? exp_word  :
                     bus.sel_ist  ? ist_word  :
                     bus.sel_imsk ? imsk_word : 16'h0000;

    // data stand only in the cycle after the strobe to keep the bus idle-low
    assign rdata_next = (bus.rd & bus.hit) ? rd_word : 16'h0000;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq       = irq_reg;
endmodule
`default_nettype wire

// ### test/anps_top_assertions.sv
// Purpose: concurrent checks on the partner status register port
// Assumes: read data answer only in the cycle after the read strobe
// Notes:   flags are judged cleared only where no new event overlaps the read
`timescale 1ns/1ps
`default_nettype none
module anps_top_assertions
    import anps_pkg::*;
(
    // watched ports
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        rx_page_stb,
    input wire logic        rx_page_base,
    input wire logic [15:0] rx_page_word,
    input wire logic        pd_fault_evt,
    input wire logic        flp_partner_ok,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire logic rd5 = reg_rd && reg_addr == LPA_ADDR;
    wire logic rd6 = reg_rd && reg_addr == EXP_ADDR;
    wire logic np_in = rx_page_word[15];
    wire logic quiet = !pd_fault_evt && !rx_page_stb;
    property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
    property p_lpa_load;
        rx_page_stb && rx_page_base ##1 !(rx_page_stb && rx_page_base) ##1 (rd5 && !rx_page_stb)
            |=> reg_rdata == ($past(rx_page_word, 3) & 16'hE1FF);
    endproperty
    property p_lpa_resv; rd5 |=> reg_rdata[12:9] == 4'h0; endproperty
    property p_exp_fixed; rd6 |=> reg_rdata[15:5] == 11'h000 && reg_rdata[2]; endproperty
    property p_np_able;
        rx_page_stb && rx_page_base ##1 (!rx_page_stb)[*3] ##1 (rd6 && !rx_page_stb)
            |=> reg_rdata[3] == $past(np_in, 5);
    endproperty
    property p_page_rx; rx_page_stb ##1 (!rd6)[*3] ##1 rd6 |=> reg_rdata[1]; endproperty
    property p_pd_fault; pd_fault_evt ##1 !rd6 ##1 rd6 |=> reg_rdata[4]; endproperty
    property p_lpan; flp_partner_ok ##1 (flp_partner_ok && rd6) |=> reg_rdata[0]; endproperty
    property p_lh_clear;
        (rd6 && quiet) ##1 quiet ##1 (rd6 && quiet) |=> reg_rdata[4] == 1'b0 && !reg_rdata[1];
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    a_lpa_load: assert property (p_lpa_load) else $error("ability word wrong");
    a_lpa_resv: assert property (p_lpa_resv) else $error("reserved ability bits set");
    a_exp_fixed: assert property (p_exp_fixed) else $error("fixed expansion bits");
    a_np_able: assert property (p_np_able) else $error("partner next page able");
    a_page_rx: assert property (p_page_rx) else $error("page received not set");
    a_pd_fault: assert property (p_pd_fault) else $error("fault flag not set");
    a_lpan: assert property (p_lpan) else $error("partner negotiation able");
    a_lh_clear: assert property (p_lh_clear) else $error("sticky flag kept");
    c_next: cover property (rx_page_stb && !rx_page_base);
    c_irq: cover property (irq ##1 !irq);
    c_pdf: cover property (pd_fault_evt ##2 rd6);
endmodule
`default_nettype wire

// ### test/anps_sta_model.sv
// Purpose: management entity reading and writing the status registers
// Assumes: slave never stalls, read data one cycle after the strobe
// Notes:   released address and data show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module anps_sta_model (
    // clock
    input  wire logic        mclk,
    // register port
    output logic      [4:0]  addr,
    output logic      [15:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [15:0] rdata
);
    initial begin
        addr = 5'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    // callers keep reserved bits at zero except where a refusal is probed
    task automatic put(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~v;
    endtask
    // one-cycle read strobe; data sampled 1 ns after the edge that takes the strobe
    task automatic get(input logic [4:0] a, output logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        addr <= ~a;
        #1 v = rdata;
    endtask
endmodule
`default_nettype wire

// ### test/anps_top_tb_top.sv
// Purpose: self-checking bench for the partner status registers
// Assumes: fixed seed, negotiation inputs driven at the rising edge
// Notes:   mask enables the page bit first, the fault bit near the end
`timescale 1ns/1ps
`default_nettype none
module anps_top_tb_top;
    logic mclk, rstn, stb, base, pd, flp;
    logic [15:0] word, d, w;
    logic [15:0] corner [3] = '{16'hFFFF, 16'h81E1, 16'h6002};
    wire logic [4:0] addr;
    wire logic [15:0] wdata, rdata;
    wire logic wr, rd, irq;
    int error_cnt, cmp_count, cyc;
    anps_top dut (.mclk(mclk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .rx_page_stb(stb),
        .rx_page_base(base), .rx_page_word(word), .pd_fault_evt(pd),
        .flp_partner_ok(flp), .irq(irq));
    anps_sta_model sta (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        sta.get(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic page(input logic [15:0] v, input logic b);
        @(posedge mclk);
        stb <= 1'b1;
        base <= b;
        word <= v;
        @(posedge mclk);
        stb <= 1'b0;
        word <= ~v;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        {rstn, stb, base, pd, flp, word} = '0;
        void'($urandom(32'hD778));
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        rchk(5'h05, 16'h0000);
        rchk(5'h06, 16'h0004);
        rchk(5'h19, 16'h0000);
        @(posedge mclk);
        flp <= 1'b1;
        repeat (2) @(posedge mclk);
        rchk(5'h06, 16'h0005);
        chk("irq", 16'h0000, {15'h0000, irq});
        sta.put(5'h19, 16'h0001);
        rchk(5'h19, 16'h0001);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            w = (i < 3) ? corner[i] : 16'($urandom);
            page(w, 1'b1);
            if (i % 2 == 1)
                page(16'($urandom), 1'b0);
            rchk(5'h05, w & 16'hE1FF);
            rchk(5'h06, {11'h000, 1'b0, w[15], 3'b111});
            rchk(5'h06, {11'h000, 1'b0, w[15], 3'b101});
        end
        chk("irq", 16'h0001, {15'h0000, irq});
        rchk(5'h18, 16'h0005);
        sta.put(5'h18, 16'h0007);
        @(posedge mclk);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        $display("test pages done");
        @(posedge mclk);
        pd <= 1'b1;
        @(posedge mclk);
        pd <= 1'b0;
        rchk(5'h06, {11'h000, 1'b1, w[15], 3'b101});
        rchk(5'h06, {11'h000, 1'b0, w[15], 3'b101});
        chk("irq", 16'h0000, {15'h0000, irq});
        sta.put(5'h06, 16'hFFFF);
        sta.put(5'h05, 16'hFFFF);
        rchk(5'h06, {11'h000, 1'b0, w[15], 3'b101});
        rchk(5'h05, w & 16'hE1FF);
        rchk(5'h1F, 16'h0000);
        rchk(5'h18, 16'h0002);
        sta.put(5'h19, 16'h0002);
        @(posedge mclk);
        #1 chk("irq", 16'h0001, {15'h0000, irq});
        sta.put(5'h18, 16'h0002);
        rchk(5'h18, 16'h0000);
        chk("irq", 16'h0000, {15'h0000, irq});
        $display("test faults and writes done");
        conclude();
    end
endmodule
bind anps_top anps_top_assertions u_chk (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_page_stb(rx_page_stb), .rx_page_base(rx_page_base), .rx_page_word(rx_page_word),
    .pd_fault_evt(pd_fault_evt), .flp_partner_ok(flp_partner_ok), .irq(irq));
`default_nettype wire
